// file: logic/control_place_arbiter.sv
// control place arbiter: source selection, forcing and command gating
//
// Contract
// - Selection value picks source: 0 pc, 1 panel, 2 fieldbus, 3 i/o.
// - Start, stop and reset accepted only from the active source.
// - Quick stop acts whatever source is active.
// - Active forcing signals override the configured selection.
// - Several forced sources: lowest priority slot index wins.
// - Winner released: next still-forced source beats the selection.
// - Forcing of a source without a priority slot is ignored.
// - A pc tool request takes control regardless of anything else.
// - Default order pc, panel, i/o, fieldbus, then the selection.
// - Forcing mode sets level or toggle for fieldbus and i/o forcing.
// - Release mode 1 moves at once; mode 0 waits for a change.
// - Passing to panel while running keeps start only if continue set.
// - Independent reset takes fault resets from every source.
// - Local mode: 0 allow, 1 no panel start, 2 no local mode.
// - With i/o active, stop input going false raises stop.
// - I/O start mode 0: start follows the start input.
// - Mode 1: latch on rise, clear on stop or low, no relatch.
// - Mode 2: latch on rise, clear only on stop.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module control_place_arbiter
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io_start_in,
  input wire logic io_stop_in,
  input wire logic io_reset_in,
  input wire logic force_fieldbus_in,
  input wire logic force_io_in,
  input wire logic remote_local_button,
  input wire logic quick_stop_n,
  input wire logic panel_start,
  input wire logic panel_stop,
  input wire logic panel_reset,
  input wire logic fieldbus_source_start,
  input wire logic fieldbus_source_stop,
  input wire logic fieldbus_source_reset,
  input wire logic pc_request,
  input wire logic pc_release,
  input wire logic pc_start,
  input wire logic pc_stop,
  input wire logic pc_reset,
  output ctrl_place_pkg::source_t active_source,
  output logic start_cmd,
  output logic stop_cmd,
  output logic fault_reset,
  output logic quick_stop
);

  import ctrl_place_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [PRIO_W-1:0] prio;
    logic [31:0] rdata;
    source_t src;
    logic [1:0] sel_q;
    logic [3:0] forced_q;
    logic fieldbus_forced;
    logic io_forced;
    logic local_forced;
    logic pc_forced;
    logic run;
    logic io_latch;
    logic start;
    logic stop;
    logic rst_pulse;
    logic qstop;
  } arb_state_t;

  arb_state_t state_reg;
  arb_state_t state_next;

  logic [IN_COUNT-1:0] raw_in;
  logic [IN_COUNT-1:0] lvl;
  logic [IN_COUNT-1:0] rise;

  // ==========================================================
  // input synchronisation
  assign raw_in = {pc_reset, pc_stop, pc_start, pc_release, pc_request,
                   fieldbus_source_reset, fieldbus_source_stop,
                   fieldbus_source_start, panel_reset, panel_stop,
                   panel_start, quick_stop_n, remote_local_button,
                   force_io_in, force_fieldbus_in, io_reset_in,
                   io_stop_in, io_start_in};

  // every pin crosses two flops before the arbiter looks at it
  edge_sync #(.WIDTH(IN_COUNT), .IDLE(IN_IDLE)) in_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .level(lvl),
    .rise(rise)
  );

  // ==========================================================
  // configuration fields
  logic [1:0] sel;
  logic [1:0] fmode;
  logic release_now;
  logic cont_local;
  logic indep_reset;
  logic [1:0] lmode;
  logic [1:0] iomode;

  assign sel = state_reg.cfg[CFG_SEL_LSB +: 2];
  assign fmode = state_reg.cfg[CFG_FMODE_LSB +: 2];
  assign release_now = state_reg.cfg[CFG_RELEASE_BIT];
  assign cont_local = state_reg.cfg[CFG_CONT_LOCAL_BIT];
  assign indep_reset = state_reg.cfg[CFG_INDEP_RESET_BIT];
  assign lmode = state_reg.cfg[CFG_LMODE_LSB +: 2];
  assign iomode = state_reg.cfg[CFG_IOMODE_LSB +: 2];

  // ==========================================================
  // apb decode helpers
  logic access;
  logic setup;
  logic mapped;

  assign access = psel & penable;
  assign setup = psel & ~penable;
  assign mapped = (paddr == CFG_OFFSET) || (paddr == PRIO_OFFSET) ||
                  (paddr == STATUS_OFFSET);

  // ==========================================================
  // arbitration and command logic
  logic [3:0] forced;
  logic found;
  source_t winner;
  source_t target;
  logic update;
  logic changed;
  logic src_start;
  logic src_stop;
  logic src_reset;
  logic stop_all;
  logic any_reset;
  logic io_active;

  always_comb
  begin
    state_next = state_reg;
    found = 1'b0;
    winner = SRC_PC;
    src_start = 1'b0;
    src_stop = 1'b0;
    src_reset = 1'b0;

    // register writes take effect at the access edge only
    if (access && pwrite)
    begin
      if (paddr == CFG_OFFSET)
        state_next.cfg = pwdata[CFG_W-1:0];
      else if (paddr == PRIO_OFFSET)
        state_next.prio = pwdata[PRIO_W-1:0];
    end

    // read data is captured in setup so access needs no wait state
    if (setup)
    begin
      if (paddr == CFG_OFFSET)
        state_next.rdata = {21'h000000, state_reg.cfg};
      else if (paddr == PRIO_OFFSET)
        state_next.rdata = {20'h00000, state_reg.prio};
      else if (paddr == STATUS_OFFSET)
        state_next.rdata = {20'h00000, state_reg.forced_q,
                            state_reg.qstop, state_reg.stop,
                            state_reg.io_latch, state_reg.run,
                            state_reg.start, 1'b0, state_reg.src};
      else
        state_next.rdata = 32'h00000000;
    end

    // forcing state: toggle flips on rise, level follows the pin
    if (fmode[0])
      state_next.fieldbus_forced = state_reg.fieldbus_forced ^
                                   rise[IN_FORCE_FIELDBUS];
    else
      state_next.fieldbus_forced = lvl[IN_FORCE_FIELDBUS];
    if (fmode[1])
      state_next.io_forced = state_reg.io_forced ^ rise[IN_FORCE_IO];
    else
      state_next.io_forced = lvl[IN_FORCE_IO];

    // the panel button toggles local forcing unless local is denied
    if (lmode == LMODE_DENY_CTRL)
      state_next.local_forced = 1'b0;
    else if (rise[IN_REMOTE_LOCAL])
      state_next.local_forced = ~state_reg.local_forced;

    // the tool holds control from its request until its release
    if (rise[IN_PC_REQUEST])
      state_next.pc_forced = 1'b1;
    else if (rise[IN_PC_RELEASE])
      state_next.pc_forced = 1'b0;

    forced = 4'h0;
    forced[SRC_PC] = state_reg.pc_forced;
    forced[SRC_LOCAL] = state_reg.local_forced;
    forced[SRC_FIELDBUS] = state_reg.fieldbus_forced;
    forced[SRC_IO] = state_reg.io_forced;

    // walk slots from last to first so slot 0 is the final winner
    for (int i = PRIO_SLOTS - 1; i >= 0; i--)
    begin
      if (state_reg.prio[3*i+2] &&
          forced[state_reg.prio[3*i +: 2]])
      begin
        found = 1'b1;
        winner = source_t'(state_reg.prio[3*i +: 2]);
      end
    end

    // tool first, then forced winner, then the configured selection
    if (state_reg.pc_forced)
      target = SRC_PC;
    else if (found)
      target = winner;
    else
      target = source_t'(sel);

    // retain mode only moves on a new forcing or a new selection
    update = release_now ||
             (|(forced & ~state_reg.forced_q)) ||
             (sel != state_reg.sel_q);
    state_next.forced_q = forced;
    state_next.sel_q = sel;
    state_next.src = update ? target : state_reg.src;
    changed = (state_next.src != state_reg.src);
    io_active = (state_reg.src == SRC_IO);

    // commands are taken from the active source only
    case (state_reg.src)
      SRC_PC:
      begin
        src_start = rise[IN_PC_START];
        src_stop = rise[IN_PC_STOP];
        src_reset = rise[IN_PC_RESET];
      end
      SRC_LOCAL:
      begin
        src_start = rise[IN_PANEL_START] &&
                    (lmode == LMODE_ALLOW);
        src_stop = rise[IN_PANEL_STOP];
        src_reset = rise[IN_PANEL_RESET];
      end
      SRC_FIELDBUS:
      begin
        src_start = rise[IN_FIELDBUS_START];
        src_stop = rise[IN_FIELDBUS_STOP];
        src_reset = rise[IN_FIELDBUS_RESET];
      end
      default:
      begin
        src_stop = ~lvl[IN_IO_STOP];
        src_reset = rise[IN_IO_RESET];
      end
    endcase

    // quick stop is never gated by the source
    state_next.qstop = ~lvl[IN_QUICK_STOP_N];
    stop_all = src_stop | state_next.qstop;
    state_next.stop = stop_all;

    // run request of the pc, panel and fieldbus sources
    if (stop_all)
      state_next.run = 1'b0;
    else if (src_start)
      state_next.run = 1'b1;
    // a new source keeps a running start only when it is the panel
    if (changed)
      state_next.run = (state_next.src == SRC_LOCAL) && cont_local &&
                       state_reg.start;

    // i/o start sensing; a held input cannot relatch without an edge
    if (!io_active || changed)
      state_next.io_latch = 1'b0;
    else if (iomode == IOMODE_EDGE)
    begin
      if (stop_all || !lvl[IN_IO_START])
        state_next.io_latch = 1'b0;
      else if (rise[IN_IO_START])
        state_next.io_latch = 1'b1;
    end
    else if (iomode == IOMODE_PULSE)
    begin
      if (stop_all)
        state_next.io_latch = 1'b0;
      else if (rise[IN_IO_START])
        state_next.io_latch = 1'b1;
    end
    else
      state_next.io_latch = 1'b0;

    if (io_active && !changed)
      state_next.start = (iomode == IOMODE_LEVEL) ?
                         lvl[IN_IO_START] :
                         state_next.io_latch;
    else
      state_next.start = state_next.run;

    // fault reset from any source when independent reset is set
    any_reset = rise[IN_PC_RESET] | rise[IN_PANEL_RESET] |
                rise[IN_FIELDBUS_RESET] | rise[IN_IO_RESET];
    state_next.rst_pulse = indep_reset ? any_reset : src_reset;
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.cfg <= CFG_RESET;
      state_reg.prio <= PRIO_RESET;
      state_reg.src <= SRC_IO;
      state_reg.sel_q <= CFG_RESET[CFG_SEL_LSB +: 2];
    end
    else
      state_reg <= state_next;
  end

  // ==========================================================
  // outputs
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = state_reg.rdata;
  assign active_source = state_reg.src;
  assign start_cmd = state_reg.start;
  assign stop_cmd = state_reg.stop;
  assign fault_reset = state_reg.rst_pulse;
  assign quick_stop = state_reg.qstop;

  // ==========================================================
  // checks
  quick_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !lvl[IN_QUICK_STOP_N] |=> stop_cmd && quick_stop)
    else $error("quick stop did not raise stop");

  pc_takeover_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.pc_forced |=> active_source == SRC_PC)
    else $error("pc request did not take control");

  io_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    io_active && !lvl[IN_IO_STOP] |=> stop_cmd && !state_reg.io_latch)
    else $error("i/o stop input ignored");

  io_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    io_active && !changed && iomode == IOMODE_LEVEL
    |=> start_cmd == $past(lvl[IN_IO_START]))
    else $error("level start does not follow input");

  pulse_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    io_active && !changed && iomode == IOMODE_PULSE &&
    state_reg.io_latch && !stop_all |=> state_reg.io_latch)
    else $error("pulse start dropped without stop");

  local_deny_a: assert property (@(posedge pclk) disable iff (!presetn)
    lmode == LMODE_DENY_CTRL |=> !state_reg.local_forced)
    else $error("local forcing while denied");

  sel_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    release_now && !(|forced) ##1 release_now && !(|forced)
    |-> active_source == source_t'($past(sel)))
    else $error("selection not applied");

  reset_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    indep_reset && rise[IN_FIELDBUS_RESET] |=> fault_reset)
    else $error("independent reset lost");

  slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !mapped |-> pslverr ##1 $stable({state_reg.cfg, state_reg.prio}))
    else $error("unmapped access mishandled");

endmodule // control_place_arbiter

`default_nettype wire

// file: logic/ctrl_place_pkg.sv
// constants and types shared by the control place arbiter
package ctrl_place_pkg;

  // ==========================================================
  // command sources
  typedef enum logic [1:0] {
    SRC_PC = 2'b00,
    SRC_LOCAL = 2'b01,
    SRC_FIELDBUS = 2'b10,
    SRC_IO = 2'b11
  } source_t;

  // ==========================================================
  // apb register byte offsets
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] PRIO_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // ==========================================================
  // configuration register fields
  localparam int CFG_W = 11;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_FMODE_LSB = 2;
  localparam int CFG_RELEASE_BIT = 4;
  localparam int CFG_CONT_LOCAL_BIT = 5;
  localparam int CFG_INDEP_RESET_BIT = 6;
  localparam int CFG_LMODE_LSB = 7;
  localparam int CFG_IOMODE_LSB = 9;
  // selection i/o, change after release, everything else zero
  localparam logic [10:0] CFG_RESET = 11'h013;

  // ==========================================================
  // priority list: four slots of {valid, source}, slot 0 first
  localparam int PRIO_SLOTS = 4;
  localparam int PRIO_W = 12;
  // pc, local, i/o, fieldbus
  localparam logic [11:0] PRIO_RESET = 12'hdec;

  // ==========================================================
  // mode encodings
  localparam logic [1:0] LMODE_ALLOW = 2'h0;
  localparam logic [1:0] LMODE_DENY_START = 2'h1;
  localparam logic [1:0] LMODE_DENY_CTRL = 2'h2;
  localparam logic [1:0] IOMODE_LEVEL = 2'h0;
  localparam logic [1:0] IOMODE_EDGE = 2'h1;
  localparam logic [1:0] IOMODE_PULSE = 2'h2;

  // ==========================================================
  // synchronised input indices
  localparam int IN_IO_START = 0;
  localparam int IN_IO_STOP = 1;
  localparam int IN_IO_RESET = 2;
  localparam int IN_FORCE_FIELDBUS = 3;
  localparam int IN_FORCE_IO = 4;
  localparam int IN_REMOTE_LOCAL = 5;
  localparam int IN_QUICK_STOP_N = 6;
  localparam int IN_PANEL_START = 7;
  localparam int IN_PANEL_STOP = 8;
  localparam int IN_PANEL_RESET = 9;
  localparam int IN_FIELDBUS_START = 10;
  localparam int IN_FIELDBUS_STOP = 11;
  localparam int IN_FIELDBUS_RESET = 12;
  localparam int IN_PC_REQUEST = 13;
  localparam int IN_PC_RELEASE = 14;
  localparam int IN_PC_START = 15;
  localparam int IN_PC_STOP = 16;
  localparam int IN_PC_RESET = 17;
  localparam int IN_COUNT = 18;
  // rest levels: i/o stop and quick stop pins idle high, all others low
  localparam logic [IN_COUNT-1:0] IN_IDLE = 18'h00042;

endpackage

// file: logic/edge_sync.sv
// two-stage synchroniser with a history stage for edge detection
`timescale 1ns/1ps
`default_nettype none

module edge_sync
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // ==========================================================
  // next state: meta feeds only the second stage
  always_comb
  begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
    state_next.prev = state_reg.stable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    // start at the pins' rest level, so no false stop or edge follows reset
    if (!presetn)
      state_reg <= {IDLE, IDLE, IDLE};
    else
      state_reg <= state_next;
  end

  // edges compare the stable copy with last cycle's value
  assign level = state_reg.stable;
  assign rise = state_reg.stable & ~state_reg.prev;

endmodule // edge_sync

`default_nettype wire

// file: tb/operator_model.sv
// behavioural model of the operator side: pins, panel, fieldbus and pc tool
`timescale 1ns/1ps
`default_nettype none

module operator_model
(
  input wire logic pclk,
  output logic [17:0] pins
);
  // ==========================================================
  // pin levels
  // i/o stop and quick stop are active low, so they idle high
  initial
  begin
    pins = 18'h00042;
  end

  // change one pin just after a rising edge, never between edges
  task automatic set(input int idx, input logic v);
    @(posedge pclk);
    pins[idx] <= v;
  endtask

  // a press held well past the two-flop sampling of the block
  task automatic pulse(input int idx);
    set(idx, 1'b1);
    repeat (4) @(posedge pclk);
    set(idx, 1'b0);
    repeat (4) @(posedge pclk);
  endtask
endmodule // operator_model
`default_nettype wire

// file: tb/test_control_place_arbiter.sv
// self-checking testbench for the control place arbiter
`timescale 1ns/1ps
`default_nettype none

module test_control_place_arbiter;
  import ctrl_place_pkg::*;

  // ==========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] pins;
  source_t active_source;
  logic start_cmd, stop_cmd, fault_reset, quick_stop;
  logic [3:0] outs;
  int fail_count = 0;
  int n_compared = 0;
  int resets_seen = 0;
  int n0;

  assign outs = {quick_stop, fault_reset, stop_cmd, start_cmd};

  // clock of 10 ns
  always #5 pclk = ~pclk;

  // one count per cycle, so a stretched pulse shows as extra counts
  always @(posedge pclk)
    if (fault_reset === 1'b1)
      resets_seen <= resets_seen + 1;

  operator_model ops (.pclk(pclk), .pins(pins));

  control_place_arbiter DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .io_start_in(pins[IN_IO_START]), .io_stop_in(pins[IN_IO_STOP]),
    .io_reset_in(pins[IN_IO_RESET]),
    .force_fieldbus_in(pins[IN_FORCE_FIELDBUS]),
    .force_io_in(pins[IN_FORCE_IO]),
    .remote_local_button(pins[IN_REMOTE_LOCAL]),
    .quick_stop_n(pins[IN_QUICK_STOP_N]),
    .panel_start(pins[IN_PANEL_START]), .panel_stop(pins[IN_PANEL_STOP]),
    .panel_reset(pins[IN_PANEL_RESET]),
    .fieldbus_source_start(pins[IN_FIELDBUS_START]),
    .fieldbus_source_stop(pins[IN_FIELDBUS_STOP]),
    .fieldbus_source_reset(pins[IN_FIELDBUS_RESET]),
    .pc_request(pins[IN_PC_REQUEST]), .pc_release(pins[IN_PC_RELEASE]),
    .pc_start(pins[IN_PC_START]), .pc_stop(pins[IN_PC_STOP]),
    .pc_reset(pins[IN_PC_RESET]), .active_source(active_source),
    .start_cmd(start_cmd), .stop_cmd(stop_cmd), .fault_reset(fault_reset),
    .quick_stop(quick_stop));

  // ==========================================================
  // compare, verdict and bus tasks
  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a failed wait ends the run, since later steps build on it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input bit last);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
      if (last)
        end_sim();
    end
  endtask

  // configuration word: flags are {independent reset, continue, release}
  function automatic logic [31:0] cfg(input logic [1:0] sel,
    input logic [1:0] fm, input logic [2:0] fl, input logic [1:0] lm,
    input logic [1:0] iom);
    cfg = {21'h0, iom, lm, fl, fm, sel};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
    input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp, 1'b0);
    chk({31'h0, err}, {31'h0, exp_err}, 1'b0);
  endtask

  // outputs move a few edges after a pin, so wait a bounded while
  task automatic chk_src(input source_t s);
    int n;
    n = 0;
    @(negedge pclk); // never look in the time step of a launching edge
    while (active_source !== s && n < 12)
    begin
      @(negedge pclk);
      n++;
    end
    chk({30'h0, active_source}, {30'h0, s}, 1'b1);
  endtask

  task automatic chk_bit(input int i, input logic v);
    int n;
    n = 0;
    @(negedge pclk); // never look in the time step of a launching edge
    while (outs[i] !== v && n < 12)
    begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, outs[i]}, {31'h0, v}, 1'b1);
  endtask

  task automatic hold();
    repeat (8) @(posedge pclk);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // register reset values and an unmapped address
    rd_chk(CFG_OFFSET, 32'h013, 1'b0);
    rd_chk(PRIO_OFFSET, 32'hdec, 1'b0);
    rd_chk(8'h0c, 32'h0, 1'b1);
    chk_src(SRC_IO);
    for (int s = 0; s < 4; s++)
    begin
      wr(CFG_OFFSET, cfg(s[1:0], 2'h0, 3'h1, 2'h0, 2'h0));
      chk_src(source_t'(s[1:0]));
    end
    // i/o level start, foreign starts, quick stop and stop input
    ops.set(IN_IO_START, 1'b1);
    chk_bit(0, 1'b1);
    ops.set(IN_IO_START, 1'b0);
    chk_bit(0, 1'b0);
    ops.pulse(IN_PANEL_START);
    ops.pulse(IN_FIELDBUS_START);
    chk_bit(0, 1'b0);
    ops.set(IN_QUICK_STOP_N, 1'b0);
    chk_bit(3, 1'b1);
    ops.set(IN_QUICK_STOP_N, 1'b1);
    chk_bit(3, 1'b0);
    ops.set(IN_IO_STOP, 1'b0);
    chk_bit(1, 1'b1);
    ops.set(IN_IO_STOP, 1'b1);
    chk_bit(1, 1'b0);
    // edge start: cleared by stop, no relatch, cleared by a low input
    wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h1, 2'h0, 2'h1));
    ops.set(IN_IO_START, 1'b1);
    chk_bit(0, 1'b1);
    ops.set(IN_IO_STOP, 1'b0);
    chk_bit(0, 1'b0);
    ops.set(IN_IO_STOP, 1'b1);
    hold();
    chk_bit(0, 1'b0);
    ops.set(IN_IO_START, 1'b0);
    ops.set(IN_IO_START, 1'b1);
    chk_bit(0, 1'b1);
    ops.set(IN_IO_START, 1'b0);
    chk_bit(0, 1'b0);
    // pulse start survives a low input, not a stop
    wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h1, 2'h0, 2'h2));
    ops.set(IN_IO_START, 1'b1);
    chk_bit(0, 1'b1);
    ops.set(IN_IO_START, 1'b0);
    hold();
    chk_bit(0, 1'b1);
    ops.set(IN_IO_STOP, 1'b0);
    chk_bit(0, 1'b0);
    ops.set(IN_IO_STOP, 1'b1);
    // running start kept or dropped when the panel takes over
    wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h3, 2'h0, 2'h0));
    ops.set(IN_IO_START, 1'b1);
    ops.pulse(IN_REMOTE_LOCAL);
    chk_src(SRC_LOCAL);
    hold();
    chk_bit(0, 1'b1);
    ops.pulse(IN_REMOTE_LOCAL);
    chk_src(SRC_IO);
    wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h1, 2'h0, 2'h0));
    ops.pulse(IN_REMOTE_LOCAL);
    chk_src(SRC_LOCAL);
    chk_bit(0, 1'b0);
    ops.pulse(IN_REMOTE_LOCAL);
    ops.set(IN_IO_START, 1'b0);
    // local mode restrictions
    wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h1, 2'h2, 2'h0));
    ops.pulse(IN_REMOTE_LOCAL);
    chk_src(SRC_IO);
    ops.pulse(IN_REMOTE_LOCAL);
    for (int m = 1; m >= 0; m--)
    begin
      wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h1, m[1:0], 2'h0));
      ops.pulse(IN_REMOTE_LOCAL);
      chk_src(SRC_LOCAL);
      ops.pulse(IN_PANEL_START);
      chk_bit(0, m == 0);
      ops.pulse(IN_PANEL_STOP);
      chk_bit(0, 1'b0);
      ops.pulse(IN_REMOTE_LOCAL);
      chk_src(SRC_IO);
    end
    // forcing over the selection, priority order and fall-back
    wr(CFG_OFFSET, cfg(2'h1, 2'h0, 3'h1, 2'h0, 2'h0));
    ops.set(IN_FORCE_IO, 1'b1);
    chk_src(SRC_IO);
    ops.set(IN_FORCE_FIELDBUS, 1'b1);
    hold();
    chk_src(SRC_IO);
    ops.set(IN_FORCE_IO, 1'b0);
    chk_src(SRC_FIELDBUS);
    ops.set(IN_FORCE_FIELDBUS, 1'b0);
    chk_src(SRC_LOCAL);
    // i/o left out of the priority list
    wr(PRIO_OFFSET, 32'hcec);
    ops.set(IN_FORCE_IO, 1'b1);
    hold();
    chk_src(SRC_LOCAL);
    ops.set(IN_FORCE_IO, 1'b0);
    wr(PRIO_OFFSET, 32'hdec);
    // pc tool takes over from a forced source
    ops.set(IN_FORCE_IO, 1'b1);
    chk_src(SRC_IO);
    ops.pulse(IN_PC_REQUEST);
    chk_src(SRC_PC);
    ops.pulse(IN_PC_RELEASE);
    chk_src(SRC_IO);
    ops.set(IN_FORCE_IO, 1'b0);
    chk_src(SRC_LOCAL);
    // retain after release until the selection changes
    wr(CFG_OFFSET, cfg(2'h1, 2'h0, 3'h0, 2'h0, 2'h0));
    ops.set(IN_FORCE_IO, 1'b1);
    chk_src(SRC_IO);
    ops.set(IN_FORCE_IO, 1'b0);
    hold();
    chk_src(SRC_IO);
    wr(CFG_OFFSET, cfg(2'h2, 2'h0, 3'h0, 2'h0, 2'h0));
    chk_src(SRC_FIELDBUS);
    // fieldbus commands act, a foreign stop does not
    ops.pulse(IN_FIELDBUS_START);
    chk_bit(0, 1'b1);
    ops.pulse(IN_PC_STOP);
    chk_bit(0, 1'b1);
    ops.pulse(IN_FIELDBUS_STOP);
    chk_bit(0, 1'b0);
    // every forcing mode: toggle holds after the press, level does not
    for (int f = 0; f < 4; f++)
    begin
      wr(CFG_OFFSET, cfg(2'h1, f[1:0], 3'h1, 2'h0, 2'h0));
      chk_src(SRC_LOCAL);
      ops.pulse(IN_FORCE_FIELDBUS);
      chk_src(f[0] ? SRC_FIELDBUS : SRC_LOCAL);
      if (f[0])
        ops.pulse(IN_FORCE_FIELDBUS);
      chk_src(SRC_LOCAL);
      ops.pulse(IN_FORCE_IO);
      chk_src(f[1] ? SRC_IO : SRC_LOCAL);
      if (f[1])
        ops.pulse(IN_FORCE_IO);
      chk_src(SRC_LOCAL);
    end
    // fault resets from a foreign source only when independent
    wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h1, 2'h0, 2'h0));
    chk_src(SRC_IO);
    n0 = resets_seen;
    ops.pulse(IN_PC_RESET);
    chk(resets_seen, n0, 1'b0);
    ops.pulse(IN_IO_RESET);
    chk(resets_seen, n0 + 1, 1'b0);
    wr(CFG_OFFSET, cfg(2'h3, 2'h0, 3'h5, 2'h0, 2'h0));
    ops.pulse(IN_PC_RESET);
    chk(resets_seen, n0 + 2, 1'b0);
    rd_chk(STATUS_OFFSET, 32'h003, 1'b0);
    end_sim();
  end
endmodule // test_control_place_arbiter
`default_nettype wire
